// *** inc/tcp_regs.svh ***
/*
  Constants of the configuration test port: register widths, instruction
  codes and fixed capture values. Assumes inclusion by its bare name from
  the design files, after the package tcp_pkg.
*/
// Contract
// - Sample TDI/TMS rising, drive TDO falling
// - Five TMS highs always reach reset
// - Controller starts in reset at power-on
// - Reset exits to idle; idle does nothing
// - Capture-DR loads the selected register
// - Capture-IR loads the identification code
// - Shift exits via Exit1 to Update or Pause
// - Program/erase style codes fire entering idle
// - Other instructions act in Update state; latch, power, reload and calibration codes fire entering idle
// - Instruction register is six bits
// - Bypass is one shift stage
// - External test and sample act as bypass
// - Codes select full, quick, signature chains
// - Latch code copies config into SRAM
// - Fetch code loads stored config into chain
// - Fetch code loads stored signature into chain
// - Program codes store signature or config
// - Identification code selects identification register
// - Fuse set, erase and bulk erase codes
// - Power down and power up requests
// - SRAM restored at power-up and on demand
// - Calibration code starts auto-calibration
// - Leading one in code means bypass
// - Identification register is 32 bits
// - Set fuse hides config until bulk erase
// - Latch scope follows last full or quick chain selection
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

`define TCP_IR_W 6
`define TCP_FULL_W 112
`define TCP_QUICK_W 40
`define TCP_SIG_W 16
`define TCP_ID_W 32

`define TCP_IR_EXTEST 6'h00
`define TCP_IR_SEL_FULL 6'h01
`define TCP_IR_SEL_QUICK 6'h02
`define TCP_IR_SEL_SIG 6'h03
`define TCP_IR_LATCH 6'h05
`define TCP_IR_FETCH_CFG 6'h06
`define TCP_IR_FETCH_SIG 6'h0A
`define TCP_IR_PROG_SIG 6'h0B
`define TCP_IR_PROG_CFG 6'h0C
`define TCP_IR_ID 6'h0D
`define TCP_IR_PROG_FUSE 6'h11
`define TCP_IR_PWR_DN 6'h12
`define TCP_IR_PWR_UP 6'h13
`define TCP_IR_RELOAD 6'h16
`define TCP_IR_ERASE_CFG 6'h17
`define TCP_IR_ERASE_SIG 6'h1B
`define TCP_IR_CAL 6'h1C
`define TCP_IR_BULK 6'h1D
`define TCP_IR_SAMPLE 6'h1E
`define TCP_IR_BYPASS 6'h3F

`endif

// *** inc/tcp_pkg.sv ***
/*
  Types of the configuration test port: the sixteen controller states.
  Assumes nothing of its surroundings.
*/
package tcp_pkg;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
    TS_PAUSE_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
    TS_EX1_IR, TS_PAUSE_IR, TS_EX2_IR, TS_UPD_IR
  } tcp_tap_state_t;

endpackage

// *** src/tcp_chain.sv ***
/*
  One capture-and-shift data register of the test port, shifted LSB first.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module tcp_chain #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic shift_in,
  input wire logic [W-1:0] load_data_in,
  input wire logic tdi_in,
  output logic [W-1:0] q_out
);

  // Parallel load wins over shift; both never come together from the TAP
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= '0;
    end else if (load_in) begin
      q_out <= load_data_in;
    end else if (shift_in) begin
      q_out <= {tdi_in, q_out[W-1:1]};
    end
  end

endmodule

// *** src/tcp_toggle_sync.sv ***
/*
  Event crossing: a toggle from another clock becomes a one-cycle pulse.
  Assumes the toggle changes at most once per several destination cycles.
*/
`timescale 1ns/100ps
module tcp_toggle_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic toggle_in,
  output logic pulse_out
);

  logic meta;
  logic sync;
  logic prev;

  // Two stages before any logic looks at the toggle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= toggle_in;
      sync <= meta;
      prev <= sync;
    end
  end

  // Each change of the toggle is one event
  assign pulse_out = sync ^ prev;

endmodule

// *** src/tcp_port.sv ***
/*
  Test access port used as the serial configuration port: controller,
  instruction register, data chains, and the command hand-off to the core.
  Assumes tck_in comes from the host and may stop between scans; the core
  side holds stored config, signature and fuse steady between commands.
*/
`timescale 1ns/100ps
`include "tcp_regs.svh"
module tcp_port
  import tcp_pkg::*;
#(
  parameter int FULL_W = `TCP_FULL_W,
  parameter int QUICK_W = `TCP_QUICK_W,
  parameter int SIG_W = `TCP_SIG_W,
  // Arbitrary identification value; LSB set as the standard wants
  parameter logic [`TCP_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic [FULL_W-1:0] stored_config_in,
  input wire logic [SIG_W-1:0] stored_signature_in,
  input wire logic readout_security_fuse_in,
  output logic cmd_strobe_out,
  output logic [`TCP_IR_W-1:0] cmd_code_out,
  output logic latch_quick_out,
  output logic [FULL_W-1:0] config_data_out,
  output logic [QUICK_W-1:0] quick_config_data_out,
  output logic [SIG_W-1:0] signature_data_out
);

  localparam int SYNC_W = FULL_W + SIG_W + 1;

  logic rst_meta;
  logic tck_rst_n;
  tcp_tap_state_t state;
  tcp_tap_state_t next_state;
  logic [`TCP_IR_W-1:0] ir_shift;
  logic [`TCP_IR_W-1:0] ir;
  logic bypass_bit;
  logic armed;
  logic latch_quick;
  logic send_tgl;
  logic [`TCP_IR_W-1:0] hold_code;
  logic hold_qsel;
  logic [FULL_W-1:0] hold_full;
  logic [QUICK_W-1:0] hold_quick;
  logic [SIG_W-1:0] hold_sig;
  logic [SYNC_W-1:0] stored_meta;
  logic [SYNC_W-1:0] stored_sync;
  logic [FULL_W-1:0] full_q;
  logic [QUICK_W-1:0] quick_q;
  logic [SIG_W-1:0] sig_q;
  logic [`TCP_ID_W-1:0] id_q;
  logic boot_done;
  logic evt_pulse;
  logic tdo_next;

  // Reset for the link domain: asserts at once, releases on tck edges
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      tck_rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      tck_rst_n <= rst_meta;
    end
  end

  // Controller register; power-on lands in Test-Logic-Reset
  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      state <= TS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Sixteen-state walk steered by TMS at each rising edge
  always_comb begin
    case (state)
      TS_RESET: next_state = tms_in ? TS_RESET : TS_IDLE;
      TS_IDLE: next_state = tms_in ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: next_state = tms_in ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: next_state = tms_in ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: next_state = tms_in ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: next_state = tms_in ? TS_UPD_DR : TS_PAUSE_DR;
      TS_PAUSE_DR: next_state = tms_in ? TS_EX2_DR : TS_PAUSE_DR;
      TS_EX2_DR: next_state = tms_in ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: next_state = tms_in ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: next_state = tms_in ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: next_state = tms_in ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: next_state = tms_in ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: next_state = tms_in ? TS_UPD_IR : TS_PAUSE_IR;
      TS_PAUSE_IR: next_state = tms_in ? TS_EX2_IR : TS_PAUSE_IR;
      TS_EX2_IR: next_state = tms_in ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: next_state = tms_in ? TS_SEL_DR : TS_IDLE;
      default: next_state = TS_RESET;
    endcase
  end

  // State decodes
  wire in_tlr = (state == TS_RESET);
  wire in_cap_dr = (state == TS_CAP_DR);
  wire in_sh_dr = (state == TS_SH_DR);
  wire in_cap_ir = (state == TS_CAP_IR);
  wire in_sh_ir = (state == TS_SH_IR);
  wire in_upd_ir = (state == TS_UPD_IR);
  wire enter_idle = (state != TS_IDLE) && (next_state == TS_IDLE);

  // Instruction shift stage and active instruction, six bits each
  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_shift <= `TCP_IR_ID;
      ir <= `TCP_IR_ID;
    end else begin
      if (in_cap_ir) begin
        ir_shift <= `TCP_IR_ID;
      end else if (in_sh_ir) begin
        ir_shift <= {tdi_in, ir_shift[`TCP_IR_W-1:1]};
      end
      if (in_tlr) begin
        ir <= `TCP_IR_ID;
      end else if (in_upd_ir) begin
        ir <= ir_shift;
      end
    end
  end

  // Chain selection from the active instruction
  wire sel_full = (ir == `TCP_IR_SEL_FULL);
  wire sel_quick = (ir == `TCP_IR_SEL_QUICK);
  wire sel_sig = (ir == `TCP_IR_SEL_SIG);
  wire sel_id = (ir == `TCP_IR_ID);
  // No boundary cells: those codes and any leading one fall to bypass
  wire is_bypass_code = ir[`TCP_IR_W-1] || (ir == `TCP_IR_EXTEST) || (ir == `TCP_IR_SAMPLE);
  // Unlisted codes also take the one-bit path so the chain stays intact
  wire sel_bypass = is_bypass_code || !(sel_full || sel_quick || sel_sig || sel_id);

  // Codes whose action waits for the next entry into Run-Test/Idle
  wire [`TCP_IR_W-1:0] new_code = in_upd_ir ? ir_shift : ir;
  wire idle_code = !new_code[`TCP_IR_W-1] && (
    (new_code == `TCP_IR_LATCH) || (new_code == `TCP_IR_PROG_SIG) ||
    (new_code == `TCP_IR_PROG_CFG) || (new_code == `TCP_IR_PROG_FUSE) ||
    (new_code == `TCP_IR_PWR_DN) || (new_code == `TCP_IR_PWR_UP) ||
    (new_code == `TCP_IR_RELOAD) || (new_code == `TCP_IR_ERASE_CFG) ||
    (new_code == `TCP_IR_ERASE_SIG) || (new_code == `TCP_IR_CAL) ||
    (new_code == `TCP_IR_BULK));
  wire arm_now = in_upd_ir ? idle_code : armed;
  wire fire = arm_now && enter_idle;

  // Fetches act in Update-IR and refill the chains before a shift-out
  wire fetch_cfg = in_upd_ir && (ir_shift == `TCP_IR_FETCH_CFG);
  wire fetch_sig = in_upd_ir && (ir_shift == `TCP_IR_FETCH_SIG);

  // Stored words from the core, quasi-static, brought over by two stages
  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      stored_meta <= '0;
      stored_sync <= '0;
    end else begin
      stored_meta <= {readout_security_fuse_in, stored_signature_in, stored_config_in};
      stored_sync <= stored_meta;
    end
  end

  wire fuse = stored_sync[SYNC_W-1];
  wire [SIG_W-1:0] stored_sig = stored_sync[FULL_W +: SIG_W];
  wire [FULL_W-1:0] stored_cfg = stored_sync[FULL_W-1:0];

  // A set fuse blanks every config read-out path until bulk erase clears it
  wire [FULL_W-1:0] full_load = fuse ? '0 : (fetch_cfg ? stored_cfg : full_q);
  wire [QUICK_W-1:0] quick_load = fuse ? '0 : quick_q;
  wire [SIG_W-1:0] sig_load = fetch_sig ? stored_sig : sig_q;

  // Capture-DR loads the chain that the instruction picked
  wire cap_full = (in_cap_dr && sel_full) || fetch_cfg;
  wire cap_quick = in_cap_dr && sel_quick;
  wire cap_sig = (in_cap_dr && sel_sig) || fetch_sig;
  wire cap_id = in_cap_dr && sel_id;

  tcp_chain #(.W(FULL_W)) u_full (
    .clk_in(tck_in),
    .rst_n_in(tck_rst_n),
    .load_in(cap_full),
    .shift_in(in_sh_dr && sel_full),
    .load_data_in(full_load),
    .tdi_in(tdi_in),
    .q_out(full_q)
  );

  tcp_chain #(.W(QUICK_W)) u_quick (
    .clk_in(tck_in),
    .rst_n_in(tck_rst_n),
    .load_in(cap_quick),
    .shift_in(in_sh_dr && sel_quick),
    .load_data_in(quick_load),
    .tdi_in(tdi_in),
    .q_out(quick_q)
  );

  tcp_chain #(.W(SIG_W)) u_sig (
    .clk_in(tck_in),
    .rst_n_in(tck_rst_n),
    .load_in(cap_sig),
    .shift_in(in_sh_dr && sel_sig),
    .load_data_in(sig_load),
    .tdi_in(tdi_in),
    .q_out(sig_q)
  );

  tcp_chain #(.W(`TCP_ID_W)) u_id (
    .clk_in(tck_in),
    .rst_n_in(tck_rst_n),
    .load_in(cap_id),
    .shift_in(in_sh_dr && sel_id),
    .load_data_in(ID_CODE),
    .tdi_in(tdi_in),
    .q_out(id_q)
  );

  // One-bit bypass stage, captures zero
  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      bypass_bit <= 1'b0;
    end else if (in_cap_dr) begin
      bypass_bit <= 1'b0;
    end else if (in_sh_dr && sel_bypass) begin
      bypass_bit <= tdi_in;
    end
  end

  // Arming, latch scope and the hand-off snapshot
  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      armed <= 1'b0;
      latch_quick <= 1'b0;
      send_tgl <= 1'b0;
      hold_code <= `TCP_IR_BYPASS;
      hold_qsel <= 1'b0;
      hold_full <= '0;
      hold_quick <= '0;
      hold_sig <= '0;
    end else begin
      armed <= (fire || in_tlr) ? 1'b0 : arm_now;
      if (in_upd_ir && (ir_shift == `TCP_IR_SEL_FULL)) begin
        latch_quick <= 1'b0;
      end else if (in_upd_ir && (ir_shift == `TCP_IR_SEL_QUICK)) begin
        latch_quick <= 1'b1;
      end
      // Snapshot so later shifting cannot disturb the core's copy
      if (fire) begin
        send_tgl <= !send_tgl;
        hold_code <= new_code;
        hold_qsel <= latch_quick;
        hold_full <= full_q;
        hold_quick <= quick_q;
        hold_sig <= sig_q;
      end
    end
  end

  // Serial output selection
  assign tdo_next = in_sh_ir ? ir_shift[0] :
                    sel_full ? full_q[0] :
                    sel_quick ? quick_q[0] :
                    sel_sig ? sig_q[0] :
                    sel_id ? id_q[0] : bypass_bit;

  // Falling edge update keeps half a period of hold for the next device
  always_ff @(negedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo_out <= 1'b1;
      tdo_oe_n_out <= 1'b1;
    end else begin
      tdo_out <= tdo_next;
      tdo_oe_n_out <= !(in_sh_dr || in_sh_ir);
    end
  end

  // Core side: command events arrive as toggles
  tcp_toggle_sync u_evt (
    .clk_in(core_clk_in),
    .rst_n_in(arst_n_in),
    .toggle_in(send_tgl),
    .pulse_out(evt_pulse)
  );

  // First core cycle after reset restores SRAM from stored config
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      boot_done <= 1'b0;
      cmd_strobe_out <= 1'b0;
      cmd_code_out <= `TCP_IR_BYPASS;
      latch_quick_out <= 1'b0;
      config_data_out <= '0;
      quick_config_data_out <= '0;
      signature_data_out <= '0;
    end else begin
      boot_done <= 1'b1;
      cmd_strobe_out <= evt_pulse || !boot_done;
      if (!boot_done) begin
        cmd_code_out <= `TCP_IR_RELOAD;
      end else if (evt_pulse) begin
        // Snapshot is stable here: a new one needs a whole IR scan
        cmd_code_out <= hold_code;
        latch_quick_out <= hold_qsel;
        config_data_out <= hold_full;
        quick_config_data_out <= hold_quick;
        signature_data_out <= hold_sig;
      end
    end
  end

  // Checks on the controller and the hand-off
  sequence seq_tms_high5;
    tms_in [*5];
  endsequence

  sequence seq_arm_entry;
    arm_now && enter_idle;
  endsequence

  AST_TLR_FIVE: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    seq_tms_high5 |=> state == TS_RESET)
    else $error("TAP not in reset after five TMS highs");

  AST_RESET_TO_IDLE: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    (in_tlr && !tms_in) |=> (state == TS_IDLE) && !armed)
    else $error("Reset did not leave to a quiet idle");

  AST_EXIT_PAUSE: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    (in_sh_dr && tms_in) ##1 !tms_in |=> state == TS_PAUSE_DR)
    else $error("Shift then Exit1 did not reach Pause");

  AST_CAPIR_ID: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    in_cap_ir |=> ir_shift == `TCP_IR_ID)
    else $error("Capture-IR did not load the identification code");

  AST_UPDIR: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    in_upd_ir |=> ir == $past(ir_shift))
    else $error("Update-IR did not take the shifted code");

  AST_BYPASS: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    (in_sh_dr && sel_bypass) |=> bypass_bit == $past(tdi_in))
    else $error("Bypass stage did not take TDI");

  AST_IDLE_FIRE: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    seq_arm_entry |=> (send_tgl != $past(send_tgl)) && (hold_code == $past(new_code)))
    else $error("Armed command not issued on idle entry");

  AST_NO_EARLY: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    !(arm_now && enter_idle) |=> $stable(send_tgl))
    else $error("Command issued outside idle entry");

  AST_FUSE: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    (fuse && in_cap_dr && sel_full) |=> full_q == '0)
    else $error("Config visible while fuse is set");

  AST_CAP_ID: assert property (@(posedge tck_in) disable iff (!tck_rst_n)
    (in_cap_dr && sel_id) |=> id_q == ID_CODE)
    else $error("Identification register not captured");

  AST_TDO_OE: assert property (@(negedge tck_in) disable iff (!tck_rst_n)
    !(in_sh_dr || in_sh_ir) |=> tdo_oe_n_out)
    else $error("TDO driven outside a shift state");

  AST_BOOT_RESTORE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    $rose(boot_done) |-> cmd_strobe_out && (cmd_code_out == `TCP_IR_RELOAD) ##1 (!cmd_strobe_out || $past(evt_pulse)))
    else $error("No SRAM restore after reset");

endmodule

// *** testbench/tcp_host_model.sv ***
/*
  Behavioural test-clock host: walks the controller, shifts chains LSB first.
  Assumes the bench calls its tasks one at a time; the clock only runs inside them.
*/
`timescale 1ns/100ps
module tcp_host_model (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_n_in
);
  logic tdo_seen;
  logic oe_n_seen;
  logic oe_n_shift;

  // Clock parked low, mode high so stray edges head for reset
  initial begin
    tck_out = 1'h0;
    tms_out = 1'h1;
    tdi_out = 1'h0;
  end

  // One 32 ns period; inputs set while low, output taken at the rise
  task automatic step(input logic tms, input logic tdi);
    tms_out = tms;
    tdi_out = tdi;
    #16;
    tck_out = 1'h1;
    tdo_seen = tdo_in;
    oe_n_seen = tdo_oe_n_in;
    #16;
    tck_out = 1'h0;
  endtask

  // Data line toggles when it carries nothing, so no stale value hides
  task automatic mv(input logic tms);
    step(tms, ~tdi_out);
  endtask

  task automatic reset5();
    repeat (5) mv(1'h1);
  endtask

  // From idle: instruction scan, then idle or stop in select-data
  task automatic ir_scan(input logic [5:0] code, input logic to_idle, output logic [5:0] cap);
    mv(1'h1);
    mv(1'h1);
    mv(1'h0);
    mv(1'h0);
    for (int i = 0; i < 6; i++) begin
      step(i == 5, code[i]);
      cap[i] = tdo_seen;
    end
    mv(1'h1);
    mv(~to_idle);
  endtask

  // From idle: data scan of n bits, optional pause after bit p
  task automatic dr_scan(input int n, input logic [111:0] din, input int p, output logic [111:0] dout);
    dout = '0;
    oe_n_shift = 1'h0;
    mv(1'h1);
    mv(1'h0);
    mv(1'h0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p, din[i]);
      dout[i] = tdo_seen;
      oe_n_shift = oe_n_shift | oe_n_seen; // Any high while shifting sticks
      if (i == p && i != n - 1) begin
        mv(1'h0);
        mv(1'h0);
        mv(1'h1);
        mv(1'h0);
      end
    end
    mv(1'h1);
    mv(1'h0);
  endtask
endmodule

// *** testbench/tap_config_port_tb_top.sv ***
/*
  Self-checking bench of the configuration test port: chains, bypass,
  identification and the command hand-off to the core clock.
  Assumes the host model is compiled first.
*/
`timescale 1ns/100ps
`include "tcp_regs.svh"
module tap_config_port_tb_top;
  localparam logic [31:0] ID_VAL = 32'h5A3C_9E17; // Arbitrary value
  logic core_clk, arst_n, tck, tms, tdi, tdo, tdo_oe_n, fuse, cmd_strobe, latch_quick;
  logic [111:0] stored_config, config_data, d, q, dout;
  logic [15:0] stored_signature, sig_data;
  logic [39:0] quick_data;
  logic [5:0] cmd_code, cap;
  logic [5:0] byp [5];
  logic [5:0] sel [3];
  logic [5:0] idle_codes [10];
  int wid [3];
  int strobes, base, errors, comparisons;

  tcp_port #(.ID_CODE(ID_VAL)) DUT (
    .core_clk_in(core_clk),
    .arst_n_in(arst_n),
    .tck_in(tck),
    .tms_in(tms),
    .tdi_in(tdi),
    .tdo_out(tdo),
    .tdo_oe_n_out(tdo_oe_n),
    .stored_config_in(stored_config),
    .stored_signature_in(stored_signature),
    .readout_security_fuse_in(fuse),
    .cmd_strobe_out(cmd_strobe),
    .cmd_code_out(cmd_code),
    .latch_quick_out(latch_quick),
    .config_data_out(config_data),
    .quick_config_data_out(quick_data),
    .signature_data_out(sig_data)
  );

  tcp_host_model host (
    .tck_out(tck),
    .tms_out(tms),
    .tdi_out(tdi),
    .tdo_in(tdo),
    .tdo_oe_n_in(tdo_oe_n)
  );

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Count hand-off pulses on the core side
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobes <= 0;
    end else if (cmd_strobe === 1'h1) begin
      strobes <= strobes + 1;
    end
  end

  function automatic logic [111:0] rnd();
    logic [127:0] r;
    r = {$urandom, $urandom, $urandom, $urandom};
    return r[111:0];
  endfunction

  // Chain content expected back: only the low n bits survive
  function automatic logic [111:0] keep(input logic [111:0] v, input int n);
    return v & ((112'h1 << n) - 112'h1);
  endfunction

  task automatic chk_data(input logic [111:0] got, input logic [111:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cmd(input logic [5:0] code, input int n);
    comparisons++;
    if (cmd_code !== code || strobes != n) begin
      errors++;
      $display("unexpected at %0t got %h %h exp %h %h", $time, cmd_code, strobes, code, n);
    end
  endtask

  // Load a code, enter idle, give the crossing time to land
  task automatic run_ir(input logic [5:0] code);
    base = strobes;
    host.ir_scan(code, 1'h1, cap);
    repeat (6) @(posedge core_clk);
  endtask

  task automatic load_chain(input logic [5:0] code, input int n, input logic [111:0] v);
    host.ir_scan(code, 1'h1, cap);
    host.dr_scan(n, v, -1, dout);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well beyond the few tens of microseconds expected
  initial begin
    #1500000;
    errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(82));
    arst_n = 1'h1;
    fuse = 1'h0;
    stored_config = rnd();
    stored_signature = 16'($urandom);
    byp = '{`TCP_IR_EXTEST, `TCP_IR_SAMPLE, `TCP_IR_BYPASS, 6'h04, 6'h20 | 6'($urandom)};
    sel = '{`TCP_IR_SEL_FULL, `TCP_IR_SEL_QUICK, `TCP_IR_SEL_SIG};
    wid = '{112, 40, 16};
    idle_codes = '{`TCP_IR_PROG_FUSE, `TCP_IR_PWR_DN, `TCP_IR_PWR_UP, `TCP_IR_RELOAD, `TCP_IR_ERASE_CFG,
                   `TCP_IR_ERASE_SIG, `TCP_IR_CAL, `TCP_IR_BULK, `TCP_IR_LATCH, `TCP_IR_PROG_SIG};
    // Assert by a real edge so every reset branch sees it, then hold
    @(posedge core_clk);
    arst_n <= 1'h0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    chk_cmd(`TCP_IR_RELOAD, 1);
    host.reset5();
    host.mv(1'h0);
    $display("test boot done");
    // Identification after capture of the instruction path
    host.ir_scan(`TCP_IR_BYPASS, 1'h1, cap);
    host.ir_scan(`TCP_IR_ID, 1'h1, cap);
    chk_data(112'(cap), 112'h0D);
    host.dr_scan(32, rnd(), -1, dout);
    chk_data(dout, 112'(ID_VAL));
    chk_data(112'(host.oe_n_shift), 112'h0);
    chk_data(112'(host.oe_n_seen), 112'h1);
    chk_data(112'(tdo_oe_n), 112'h1);
    host.ir_scan(`TCP_IR_BYPASS, 1'h1, cap);
    repeat ($urandom_range(20)) host.mv(1'($urandom));
    host.reset5();
    host.mv(1'h0);
    host.dr_scan(32, rnd(), -1, dout);
    chk_data(dout, 112'(ID_VAL));
    $display("test ident done");
    foreach (byp[k]) begin
      d = rnd();
      load_chain(byp[k], 8, d);
      chk_data(112'(dout[7:1]), 112'(d[6:0]));
    end
    $display("test bypass done");
    // Known last command, whatever the random walk may have issued
    run_ir(`TCP_IR_RELOAD);
    chk_cmd(`TCP_IR_RELOAD, base + 1);
    base = strobes;
    repeat (2) begin
      foreach (wid[k]) begin
        d = rnd();
        host.ir_scan(sel[k], 1'h1, cap);
        host.dr_scan(wid[k], d, $urandom_range(wid[k] - 2), dout);
        host.dr_scan(wid[k], rnd(), -1, dout);
        chk_data(dout, keep(d, wid[k]));
      end
    end
    d = rnd();
    @(posedge core_clk);
    stored_config <= d;
    stored_signature <= 16'($urandom);
    host.ir_scan(`TCP_IR_FETCH_CFG, 1'h1, cap);
    load_chain(`TCP_IR_SEL_FULL, 112, rnd());
    chk_data(dout, d);
    host.ir_scan(`TCP_IR_FETCH_SIG, 1'h1, cap);
    load_chain(`TCP_IR_SEL_SIG, 16, rnd());
    chk_data(dout, 112'(stored_signature));
    chk_cmd(`TCP_IR_RELOAD, base);
    $display("test chains done");
    d = rnd();
    load_chain(`TCP_IR_SEL_FULL, 112, d);
    run_ir(`TCP_IR_LATCH);
    chk_cmd(`TCP_IR_LATCH, base + 1);
    chk_data(config_data, d);
    chk_data(112'(latch_quick), 112'h0);
    q = rnd();
    load_chain(`TCP_IR_SEL_QUICK, 40, q);
    run_ir(`TCP_IR_LATCH);
    chk_data(112'(quick_data), keep(q, 40));
    chk_data(112'(latch_quick), 112'h1);
    load_chain(`TCP_IR_SEL_SIG, 16, q);
    run_ir(`TCP_IR_PROG_SIG);
    chk_data(112'(sig_data), keep(q, 16));
    // Program armed in update, fired only at the later idle entry
    load_chain(`TCP_IR_SEL_FULL, 112, d);
    base = strobes;
    host.ir_scan(`TCP_IR_PROG_CFG, 1'h0, cap);
    repeat (6) @(posedge core_clk);
    chk_cmd(`TCP_IR_PROG_SIG, base);
    host.mv(1'h0);
    host.mv(1'h1);
    host.mv(1'h1);
    host.mv(1'h0);
    repeat (6) @(posedge core_clk);
    chk_cmd(`TCP_IR_PROG_CFG, base + 1);
    chk_data(config_data, d);
    foreach (idle_codes[k]) begin
      run_ir(idle_codes[k]);
      chk_cmd(idle_codes[k], base + 1);
    end
    $display("test commands done");
    @(posedge core_clk);
    fuse <= 1'h1;
    load_chain(`TCP_IR_SEL_FULL, 112, rnd());
    host.dr_scan(112, rnd(), -1, dout);
    chk_data(dout, 112'h0);
    host.ir_scan(`TCP_IR_FETCH_CFG, 1'h1, cap);
    load_chain(`TCP_IR_SEL_FULL, 112, rnd());
    chk_data(dout, 112'h0);
    $display("test fuse done");
    print_verdict();
  end
endmodule
